// file: pkg/pin_select_consts.vh
// Register map and field constants for the input pin select multiplexer
`ifndef PIN_SELECT_CONSTS_VH
`define PIN_SELECT_CONSTS_VH

// Register byte offsets on the APB
`define OFS_UART1_RX     12'h000
`define OFS_UART2_RX     12'h004
`define OFS_SPI2_CLK_DAT 12'h008
`define OFS_SPI2_SEL     12'h00c
`define OFS_CAN_RX       12'h010
`define OFS_PWM_SYNC     12'h014
`define OFS_DTC_FIRST    12'h018
`define OFS_DTC_SEC_THI  12'h01c

// Select field placement
`define CODE_W           7
`define LOW_FIELD_LSB    0
`define HIGH_FIELD_LSB   8

// Byte lane strobes that guard each field
`define LOW_LANE         0
`define HIGH_LANE        1

// Source codes
`define CODE_GROUND      7'h00
`define CODE_COMPARATOR  7'h01
`define CODE_TOP_PIN     7'h79

// Field reset value
`define CODE_RESET       7'h00

// Number of remappable pins seen (index 0..121)
`define PIN_COUNT        122

`endif

// file: hw/input_pin_select_mux.v
// Input side of the remappable peripheral pin multiplexer with APB registers
//
// How it works
// - First UART receive input follows the 7-bit code in bits 6-0.
// - Second UART receive input follows the 7-bit code in bits 6-0.
// - Second SPI clock input follows code in bits 14-8 of shared register.
// - Second SPI data input follows code in bits 6-0 of shared register.
// - Second SPI active-low select follows code in bits 6-0 of its register.
// - CAN receive input follows the 7-bit code in bits 6-0.
// - PWM sync input follows code in bits 14-8; bits 7-0 unused.
// - First dead-time compensation input follows code in bits 14-8.
// - Third dead-time compensation input follows bits 14-8 of shared register.
// - Second dead-time compensation input follows bits 6-0 of shared register.
// - Highest code 121 routes remappable input pin 121.
// - Code one routes comparator one output instead of a pin.
// - Code zero ties the routed input low.
// - Bits outside select fields are unimplemented and read zero.
// - Select fields are read/write and reset to zero.
`timescale 1ns/1ps
`include "pin_select_consts.vh"

module input_pin_select_mux (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Pin and comparator sources
  input  wire [`PIN_COUNT-1:0] remappable_pin,
  input  wire        comparator_one_output,
  // Routed peripheral inputs
  output reg         uart1_receive_input,
  output reg         uart2_receive_input,
  output reg         spi2_clock_input,
  output reg         spi2_data_input,
  output reg         spi2_select_input_n,
  output reg         can_receive_input,
  output reg         pwm_sync_input,
  output reg         deadtime_comp_first_input,
  output reg         deadtime_comp_second_input,
  output reg         deadtime_comp_third_input
);

  // Select fields
  reg [`CODE_W-1:0] uart1_receive_source_code;
  reg [`CODE_W-1:0] uart2_receive_source_code;
  reg [`CODE_W-1:0] spi2_clock_source_code;
  reg [`CODE_W-1:0] spi2_data_in_source_code;
  reg [`CODE_W-1:0] spi2_select_source_code;
  reg [`CODE_W-1:0] can_receive_source_code;
  reg [`CODE_W-1:0] pwm_sync_source_code;
  reg [`CODE_W-1:0] deadtime_comp_first_source;
  reg [`CODE_W-1:0] deadtime_comp_second_source;
  reg [`CODE_W-1:0] deadtime_comp_third_source;

  // Pins arrive asynchronously: three flops, a change taken once stages 2 and 3 agree
  reg  [`PIN_COUNT-1:0] pin_meta;
  reg  [`PIN_COUNT-1:0] pin_sync2;
  reg  [`PIN_COUNT-1:0] pin_sync3;
  reg  [`PIN_COUNT-1:0] pin_clean;
  reg  [2:0]            cmp_sync;
  reg                   cmp_clean;

  wire access    = psel & penable;
  wire wr_access = access & pwrite;
  wire mapped;

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // Address decode, shared by writes and the error answer; reads decode paddr in their own case
  wire hit_uart1    = (paddr == `OFS_UART1_RX);
  wire hit_uart2    = (paddr == `OFS_UART2_RX);
  wire hit_spi2_cd  = (paddr == `OFS_SPI2_CLK_DAT);
  wire hit_spi2_sel = (paddr == `OFS_SPI2_SEL);
  wire hit_can      = (paddr == `OFS_CAN_RX);
  wire hit_sync     = (paddr == `OFS_PWM_SYNC);
  wire hit_dtc1     = (paddr == `OFS_DTC_FIRST);
  wire hit_dtc23    = (paddr == `OFS_DTC_SEC_THI);

  // Unmapped addresses answer with an error, writes to them are dropped
  assign mapped = hit_uart1 | hit_uart2 |
                  hit_spi2_cd | hit_spi2_sel |
                  hit_can | hit_sync |
                  hit_dtc1 | hit_dtc23;

  // Route one source from a code; undefined codes fall back to ground
  function route;
    input [`CODE_W-1:0]    code;
    input [`PIN_COUNT-1:0] pins;
    input                  cmp;
    begin
      if (code == `CODE_GROUND) begin
        route = 1'b0;
      end else if (code == `CODE_COMPARATOR) begin
        route = cmp;
      end else if (code <= `CODE_TOP_PIN) begin
        route = pins[code];
      end else begin
        route = 1'b0;
      end
    end
  endfunction

  // Place a code into a 32-bit read word at a field position
  function [31:0] low_field;
    input [`CODE_W-1:0] code;
    begin
      low_field = {25'h0000000, code} << `LOW_FIELD_LSB;
    end
  endfunction

  function [31:0] high_field;
    input [`CODE_W-1:0] code;
    begin
      high_field = {25'h0000000, code} << `HIGH_FIELD_LSB;
    end
  endfunction

  // Pin synchronisers; a level is taken once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta  <= {`PIN_COUNT{1'b0}};
      pin_sync2 <= {`PIN_COUNT{1'b0}};
      pin_sync3 <= {`PIN_COUNT{1'b0}};
      pin_clean <= {`PIN_COUNT{1'b0}};
    end else begin
      pin_meta  <= remappable_pin;
      pin_sync2 <= pin_meta;
      pin_sync3 <= pin_sync2;
      pin_clean <= (pin_sync2 & pin_sync3) | (pin_clean & (pin_sync2 | pin_sync3));
    end
  end

  // Comparator output is asynchronous to pclk as well
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_sync  <= 3'h0;
      cmp_clean <= 1'b0;
    end else begin
      cmp_sync <= {cmp_sync[1:0], comparator_one_output};
      // A single disagreeing sample holds the old level
      if (cmp_sync[1] == cmp_sync[2]) begin
        cmp_clean <= cmp_sync[2];
      end
    end
  end

  // Write enables per register; the field's byte lane must be strobed too
  wire wr_uart1    = wr_access & hit_uart1;
  wire wr_uart2    = wr_access & hit_uart2;
  wire wr_spi2_cd  = wr_access & hit_spi2_cd;
  wire wr_spi2_sel = wr_access & hit_spi2_sel;
  wire wr_can      = wr_access & hit_can;
  wire wr_sync     = wr_access & hit_sync;
  wire wr_dtc1     = wr_access & hit_dtc1;
  wire wr_dtc23    = wr_access & hit_dtc23;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart1_receive_source_code <= `CODE_RESET;
    end else if (wr_uart1 && pstrb[`LOW_LANE]) begin
      uart1_receive_source_code <= pwdata[`LOW_FIELD_LSB +: `CODE_W];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart2_receive_source_code <= `CODE_RESET;
    end else if (wr_uart2 && pstrb[`LOW_LANE]) begin
      uart2_receive_source_code <= pwdata[`LOW_FIELD_LSB +: `CODE_W];
    end
  end

  // Clock and data share one register; each lane writes only its own field
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi2_clock_source_code <= `CODE_RESET;
    end else if (wr_spi2_cd && pstrb[`HIGH_LANE]) begin
      spi2_clock_source_code <= pwdata[`HIGH_FIELD_LSB +: `CODE_W];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi2_data_in_source_code <= `CODE_RESET;
    end else if (wr_spi2_cd && pstrb[`LOW_LANE]) begin
      spi2_data_in_source_code <= pwdata[`LOW_FIELD_LSB +: `CODE_W];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi2_select_source_code <= `CODE_RESET;
    end else if (wr_spi2_sel && pstrb[`LOW_LANE]) begin
      spi2_select_source_code <= pwdata[`LOW_FIELD_LSB +: `CODE_W];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      can_receive_source_code <= `CODE_RESET;
    end else if (wr_can && pstrb[`LOW_LANE]) begin
      can_receive_source_code <= pwdata[`LOW_FIELD_LSB +: `CODE_W];
    end
  end

  // The low byte of this register holds nothing, so its lane is ignored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_sync_source_code <= `CODE_RESET;
    end else if (wr_sync && pstrb[`HIGH_LANE]) begin
      pwm_sync_source_code <= pwdata[`HIGH_FIELD_LSB +: `CODE_W];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deadtime_comp_first_source <= `CODE_RESET;
    end else if (wr_dtc1 && pstrb[`HIGH_LANE]) begin
      deadtime_comp_first_source <= pwdata[`HIGH_FIELD_LSB +: `CODE_W];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deadtime_comp_third_source <= `CODE_RESET;
    end else if (wr_dtc23 && pstrb[`HIGH_LANE]) begin
      deadtime_comp_third_source <= pwdata[`HIGH_FIELD_LSB +: `CODE_W];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deadtime_comp_second_source <= `CODE_RESET;
    end else if (wr_dtc23 && pstrb[`LOW_LANE]) begin
      deadtime_comp_second_source <= pwdata[`LOW_FIELD_LSB +: `CODE_W];
    end
  end

  // Read words; every bit outside a field is zero
  wire [31:0] word_uart1    = low_field(uart1_receive_source_code);
  wire [31:0] word_uart2    = low_field(uart2_receive_source_code);
  wire [31:0] word_spi2_cd  = high_field(spi2_clock_source_code) |
                              low_field(spi2_data_in_source_code);
  wire [31:0] word_spi2_sel = low_field(spi2_select_source_code);
  wire [31:0] word_can      = low_field(can_receive_source_code);
  wire [31:0] word_sync     = high_field(pwm_sync_source_code);
  wire [31:0] word_dtc1     = high_field(deadtime_comp_first_source);
  wire [31:0] word_dtc23    = high_field(deadtime_comp_third_source) |
                              low_field(deadtime_comp_second_source);

  // Zero wait states: the word must be ready within the access cycle
  always @* begin
    case (paddr)
      `OFS_UART1_RX:     prdata = word_uart1;
      `OFS_UART2_RX:     prdata = word_uart2;
      `OFS_SPI2_CLK_DAT: prdata = word_spi2_cd;
      `OFS_SPI2_SEL:     prdata = word_spi2_sel;
      `OFS_CAN_RX:       prdata = word_can;
      `OFS_PWM_SYNC:     prdata = word_sync;
      `OFS_DTC_FIRST:    prdata = word_dtc1;
      `OFS_DTC_SEC_THI:  prdata = word_dtc23;
      default:           prdata = 32'h00000000;
    endcase
  end

  // Selected levels; one flop stage follows so a code change cannot glitch
  wire next_uart1_receive_input = route(uart1_receive_source_code, pin_clean, cmp_clean);
  wire next_uart2_receive_input = route(uart2_receive_source_code, pin_clean, cmp_clean);
  wire next_spi2_clock_input    = route(spi2_clock_source_code, pin_clean, cmp_clean);
  wire next_spi2_data_input     = route(spi2_data_in_source_code, pin_clean, cmp_clean);
  wire next_spi2_select_input_n = route(spi2_select_source_code, pin_clean, cmp_clean);
  wire next_can_receive_input   = route(can_receive_source_code, pin_clean, cmp_clean);
  wire next_pwm_sync_input      = route(pwm_sync_source_code, pin_clean, cmp_clean);
  wire next_deadtime_comp_first_input  = route(deadtime_comp_first_source, pin_clean,
                                               cmp_clean);
  wire next_deadtime_comp_second_input = route(deadtime_comp_second_source, pin_clean,
                                               cmp_clean);
  wire next_deadtime_comp_third_input  = route(deadtime_comp_third_source, pin_clean,
                                               cmp_clean);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart1_receive_input <= 1'b0;
    end else begin
      uart1_receive_input <= next_uart1_receive_input;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart2_receive_input <= 1'b0;
    end else begin
      uart2_receive_input <= next_uart2_receive_input;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi2_clock_input <= 1'b0;
    end else begin
      spi2_clock_input <= next_spi2_clock_input;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi2_data_input <= 1'b0;
    end else begin
      spi2_data_input <= next_spi2_data_input;
    end
  end

  // Select is routed as-is; a ground code leaves the slave selected
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spi2_select_input_n <= 1'b0;
    end else begin
      spi2_select_input_n <= next_spi2_select_input_n;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      can_receive_input <= 1'b0;
    end else begin
      can_receive_input <= next_can_receive_input;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_sync_input <= 1'b0;
    end else begin
      pwm_sync_input <= next_pwm_sync_input;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deadtime_comp_first_input <= 1'b0;
    end else begin
      deadtime_comp_first_input <= next_deadtime_comp_first_input;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deadtime_comp_second_input <= 1'b0;
    end else begin
      deadtime_comp_second_input <= next_deadtime_comp_second_input;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deadtime_comp_third_input <= 1'b0;
    end else begin
      deadtime_comp_third_input <= next_deadtime_comp_third_input;
    end
  end

endmodule

// file: verification/pin_select_checker_sva.sv
// Concurrent checks on the pin select mux ports
`timescale 1ns/1ps
module pin_select_checker (
  // APB side
  input logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input logic [11:0] paddr,
  input logic [31:0] pwdata, prdata,
  input logic [3:0]  pstrb,
  // Routed outputs
  input logic        uart1_receive_input, uart2_receive_input, pwm_sync_input
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire rd = acc && !pwrite;
  wire wr = acc && pwrite;
  wire mapped = paddr <= 12'h01c && paddr[1:0] == 2'b00;
  a_unmapped_err: assert property (acc && !mapped |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (acc && mapped |-> pready && !pslverr)
    else $error("mapped access refused");
  a_unmapped_zero: assert property (rd && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_low_only: assert property (rd && paddr inside {12'h000, 12'h004, 12'h00c, 12'h010}
    |-> prdata[31:7] == 25'h0) else $error("low field register high bits set");
  a_high_only: assert property (rd && paddr inside {12'h014, 12'h018}
    |-> prdata[31:15] == 17'h0 && prdata[7:0] == 8'h0) else $error("high field gaps set");
  a_split_gaps: assert property (rd && paddr inside {12'h008, 12'h01c}
    |-> prdata[31:15] == 17'h0 && !prdata[7]) else $error("split register gaps set");
  a_reset_clear: assert property ($rose(presetn) |-> !uart1_receive_input && !pwm_sync_input)
    else $error("routed input high after reset");
  a_ground_route: assert property (wr && paddr == 12'h000 && pstrb[0] && pwdata[6:0] == 7'h00
    |=> ##1 !uart1_receive_input) else $error("ground code not low");
  a_over_top_low: assert property (wr && paddr == 12'h004 && pstrb[0] && pwdata[6:0] > 7'h79
    |=> ##1 !uart2_receive_input) else $error("undefined code not low");
  a_sync_ground: assert property (wr && paddr == 12'h014 && pstrb[1] && pwdata[14:8] == 7'h00
    |=> ##1 !pwm_sync_input) else $error("sync ground code not low");
  c_unmapped: cover property (acc && !mapped);
  c_split_read: cover property (rd && paddr == 12'h01c);
  c_uart_rise: cover property ($rose(uart1_receive_input));
endmodule

// file: verification/pin_source_model.sv
// Pin and comparator level source on the board side of the mux
`timescale 1ns/1ps
module pin_source_model (
  input  logic         pclk,
  input  logic         shuffle,
  output logic [121:0] pins,
  output logic         cmp
);
  logic [127:0] state = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
  // Levels hold between shuffles so the synchronisers can settle
  always @(posedge pclk) begin
    if (shuffle) begin
      state <= {state[96:0], state[127:97]} ^ {state[120:0], 7'h5b};
    end
  end
  assign pins = state[121:0];
  assign cmp = state[127];
endmodule

// file: verification/input_pin_select_mux_bench.sv
// Self-checking bench for the input pin select mux
`timescale 1ns/1ps
`include "pin_select_consts.vh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module input_pin_select_mux_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, cmp, err;
  logic shuffle = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'heb0e070a;
  logic [3:0] pstrb = 4'h0;
  logic [121:0] pins;
  logic [9:0] routed, exp_routed;
  logic [6:0] code [10];
  logic [31:0] word [8];
  int error_cnt = 0, samples_checked = 0;
  localparam int reg_of [10] = '{0, 1, 2, 2, 3, 4, 5, 6, 7, 7};
  localparam logic [9:0] hi_field = 10'b1011000100;
  localparam logic [31:0] mask [8] = '{32'h7f, 32'h7f, 32'h7f7f, 32'h7f, 32'h7f, 32'h7f00,
    32'h7f00, 32'h7f7f};
  localparam logic [6:0] corner [4] = '{`CODE_GROUND, `CODE_COMPARATOR, `CODE_TOP_PIN, 7'h7f};
  always #12.5 pclk = ~pclk;
  pin_source_model u_src (.pclk(pclk), .shuffle(shuffle), .pins(pins), .cmp(cmp));
  input_pin_select_mux u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .remappable_pin(pins), .comparator_one_output(cmp),
    .uart1_receive_input(routed[0]), .uart2_receive_input(routed[1]),
    .spi2_clock_input(routed[2]), .spi2_data_input(routed[3]), .spi2_select_input_n(routed[4]),
    .can_receive_input(routed[5]), .pwm_sync_input(routed[6]),
    .deadtime_comp_first_input(routed[7]), .deadtime_comp_second_input(routed[8]),
    .deadtime_comp_third_input(routed[9]));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic pick(logic [6:0] c, logic [121:0] p, logic m);
    if (c == `CODE_GROUND) return 1'b0;
    if (c == `CODE_COMPARATOR) return m;
    return (c <= `CODE_TOP_PIN) ? p[c] : 1'b0;
  endfunction
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= w ? 4'hf : 4'h0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 8);
    if (n == 8) begin error_cnt++; test_done(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    int r;
    logic [31:0] d;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(0, 12'(i * 4), 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    `CHK("routed after reset", 10'h0, routed)
    $display("reset test done");
    for (int i = 0; i < 40; i++) begin
      r = rnd() % 8;
      d = rnd();
      apb(1, 12'(r * 4), d);
      apb(0, 12'(r * 4), 32'h0);
      `CHK("read back", d & mask[r], rd)
    end
    apb(1, 12'h020, 32'hffff_ffff);
    `CHK("unmapped error", 1'b1, err)
    apb(0, 12'h020, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    $display("register test done");
    // In the first four rounds neighbouring fields get different corner codes so a swapped field shows
    for (int t = 0; t < 20; t++) begin
      for (int i = 0; i < 8; i++) word[i] = 32'h0;
      for (int k = 0; k < 10; k++) begin
        code[k] = (t < 4) ? corner[(t + k) % 4] : 7'(rnd());
        word[reg_of[k]] |= 32'(code[k]) << (hi_field[k] ? 8 : 0);
      end
      for (int i = 0; i < 8; i++) apb(1, 12'(i * 4), word[i]);
      shuffle <= 1'b1;
      @(posedge pclk);
      shuffle <= 1'b0;
      repeat (8) @(posedge pclk);
      for (int k = 0; k < 10; k++) exp_routed[k] = pick(code[k], pins, cmp);
      `CHK("routed inputs", exp_routed, routed)
      `CHK("pwm sync input", exp_routed[6], routed[6])
    end
    $display("routing test done");
    test_done();
  end
endmodule
bind input_pin_select_mux pin_select_checker u_chk (.*);
